// ===== pkg/blank_gate_pkg.sv
// Functional notes
// - Gating clock runs only when enable set
// - Gating clock = clock/max(prescale,1)/(divider+1)/2
// - Sixteen-bit master duty register, resets zero
// - Mask inputs on enabled output level states
// - Mask inputs on selected blanking signal level
// - Unimplemented control bits read as zero
`default_nettype none
package blank_gate_pkg;
   // ---------------------------------------------------------------
   // Register offsets (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0]  GATE_CLK_OFS    = 8'h00;
   localparam logic [7:0]  DUTY_OFS        = 8'h04;
   localparam logic [7:0]  BLANK_CTRL_OFS  = 8'h08;
   localparam logic [7:0]  AUX_CTRL_OFS    = 8'h0C;
   localparam logic [7:0]  BLANK_TIME_OFS  = 8'h10;
   localparam logic [7:0]  STATUS_OFS      = 8'h14;
   // ---------------------------------------------------------------
   // Field positions, masks and reset values
   // ---------------------------------------------------------------
   localparam int          GATE_EN_BIT     = 15;
   localparam logic [15:0] GATE_CLK_MASK   = 16'h83FF;
   localparam logic [15:0] BLANK_CTRL_MASK = 16'hFC3F;
   localparam int          HR_BIT          = 15;
   localparam int          HF_BIT          = 14;
   localparam int          LR_BIT          = 13;
   localparam int          LF_BIT          = 12;
   localparam int          FLT_EN_BIT      = 11;
   localparam int          CL_EN_BIT       = 10;
   localparam int          SEL_HI_BIT      = 5;
   localparam int          SEL_LO_BIT      = 4;
   localparam int          HH_BIT          = 3;
   localparam int          HL_BIT          = 2;
   localparam int          LH_BIT          = 1;
   localparam int          LL_BIT          = 0;
   localparam logic [15:0] REG_RESET       = 16'h0000;
   localparam logic [2:0]  PRESCALE_RESET  = 3'h0;
endpackage
`default_nettype wire

// ===== rtl/blank_gate.sv
`default_nettype none
module blank_gate
   import blank_gate_pkg::*;
#(
   parameter int SEL_COUNT = 16
) (
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire logic                 high_side_output,
   input  wire logic                 low_side_output,
   input  wire logic [SEL_COUNT-1:0] blank_sources,
   input  wire logic                 fault_in,
   input  wire logic                 current_limit_in,
   output logic                      fault_out,
   output logic                      current_limit_out,
   output logic                      gating_clk,
   output logic      [15:0]          master_duty_value
);
   // ---------------------------------------------------------------
   // Register bus
   // ---------------------------------------------------------------
   logic [15:0] gate_q, gate_d, duty_q, duty_d, blank_q, blank_d, time_q, time_d;
   logic [3:0]  sel_q, sel_d;
   logic [2:0]  pre_q, pre_d;
   logic        wr;
   logic        mapped;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      return a == o;
   endfunction

   assign wr      = psel & penable & pwrite;
   assign pready  = 1'b1;             // Zero wait states
   assign mapped  = hit(paddr, GATE_CLK_OFS) | hit(paddr, DUTY_OFS) |
                    hit(paddr, BLANK_CTRL_OFS) | hit(paddr, AUX_CTRL_OFS) |
                    hit(paddr, BLANK_TIME_OFS) | hit(paddr, STATUS_OFS);
   assign pslverr = psel & penable & ~mapped;

   // Register next values
   always_comb begin
      gate_d  = gate_q;
      duty_d  = duty_q;
      blank_d = blank_q;
      sel_d   = sel_q;
      pre_d   = pre_q;
      time_d  = time_q;
      if (wr) begin
         if (hit(paddr, GATE_CLK_OFS)) gate_d = pwdata[15:0] & GATE_CLK_MASK;
         if (hit(paddr, DUTY_OFS)) duty_d = pwdata[15:0];
         if (hit(paddr, BLANK_CTRL_OFS)) blank_d = pwdata[15:0] & BLANK_CTRL_MASK;
         if (hit(paddr, AUX_CTRL_OFS)) begin
            sel_d = pwdata[3:0];
            pre_d = pwdata[6:4];
         end
         if (hit(paddr, BLANK_TIME_OFS)) time_d = pwdata[15:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gate_q  <= REG_RESET;
         duty_q  <= REG_RESET;
         blank_q <= REG_RESET;
         sel_q   <= 4'h0;
         pre_q   <= PRESCALE_RESET;
         time_q  <= REG_RESET;
      end else begin
         gate_q  <= gate_d;
         duty_q  <= duty_d;
         blank_q <= blank_d;
         sel_q   <= sel_d;
         pre_q   <= pre_d;
         time_q  <= time_d;
      end
   end

   assign master_duty_value = duty_q;

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   localparam int SW = SEL_COUNT + 4;
   logic [SW-1:0] s1_q, s2_q, prev_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q   <= '0;
         s2_q   <= '0;
         prev_q <= '0;
      end else begin
         s1_q   <= {blank_sources, current_limit_in, fault_in, low_side_output,
                    high_side_output};
         s2_q   <= s1_q;
         prev_q <= s2_q;
      end
   end
   logic hs, ls, hs_p, ls_p, flt, cl, sel_sig;
   assign hs      = s2_q[0];
   assign ls      = s2_q[1];
   assign flt     = s2_q[2];
   assign cl      = s2_q[3];
   assign hs_p    = prev_q[0];
   assign ls_p    = prev_q[1];
   assign sel_sig = (int'(sel_q) < SEL_COUNT) ? s2_q[4 + int'(sel_q)] : 1'b0;

   // ---------------------------------------------------------------
   // Leading-edge blanking
   // ---------------------------------------------------------------
   logic        trig, state_blank, edge_blank, blank;
   logic [15:0] cnt_q, cnt_d;
   // Edge triggers, each gated by its own enable
   assign trig = (blank_q[HR_BIT] & hs & ~hs_p) | (blank_q[HF_BIT] & ~hs & hs_p) |
                 (blank_q[LR_BIT] & ls & ~ls_p) | (blank_q[LF_BIT] & ~ls & ls_p);
   // Level blanking from output states and selected signal
   assign state_blank = (blank_q[HH_BIT] & hs) | (blank_q[HL_BIT] & ~hs) |
                        (blank_q[LH_BIT] & ls) | (blank_q[LL_BIT] & ~ls) |
                        (blank_q[SEL_HI_BIT] & sel_sig) |
                        (blank_q[SEL_LO_BIT] & ~sel_sig);
   assign edge_blank  = cnt_q != 16'h0000;
   // Trigger cycle itself is blanked, so a fault that arrives with the edge never slips out
   assign blank       = state_blank | edge_blank | trig;

   // Counter reloads on a trigger, then counts down to zero
   always_comb begin
      cnt_d = cnt_q;
      if (trig) cnt_d = time_q;
      else if (edge_blank) cnt_d = cnt_q - 16'h0001;
   end

   logic flt_q, cl_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 16'h0000;
         flt_q <= 1'b0;
         cl_q  <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         flt_q <= flt & ~(blank & blank_q[FLT_EN_BIT]);
         cl_q  <= cl & ~(blank & blank_q[CL_EN_BIT]);
      end
   end
   assign fault_out         = flt_q;
   assign current_limit_out = cl_q;

   // ---------------------------------------------------------------
   // Gating clock generator
   // ---------------------------------------------------------------
   logic [2:0]  pc_q, pc_d;
   logic [9:0]  dc_q, dc_d;
   logic        gclk_q, gclk_d, pre_tick;
   // Prescale 0 and 1 both divide by one, else divide by the value
   assign pre_tick = (pre_q <= 3'h1) | (pc_q >= (pre_q - 3'h1));
   // Two-stage divide; output toggles per terminal count
   always_comb begin
      pc_d   = 3'h0;
      dc_d   = 10'h000;
      gclk_d = 1'b0;
      if (gate_q[GATE_EN_BIT]) begin
         gclk_d = gclk_q;
         pc_d   = pre_tick ? 3'h0 : pc_q + 3'h1;
         dc_d   = dc_q;
         if (pre_tick) begin
            if (dc_q >= gate_q[9:0]) begin
               dc_d   = 10'h000;
               gclk_d = ~gclk_q;
            end else dc_d = dc_q + 10'h001;
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_q   <= 3'h0;
         dc_q   <= 10'h000;
         gclk_q <= 1'b0;
      end else begin
         pc_q   <= pc_d;
         dc_q   <= dc_d;
         gclk_q <= gclk_d;
      end
   end
   assign gating_clk = gclk_q;

   // Read data
   always_comb begin
      prdata = 32'h0000_0000;
      if (hit(paddr, GATE_CLK_OFS)) prdata[15:0] = gate_q;
      if (hit(paddr, DUTY_OFS)) prdata[15:0] = duty_q;
      if (hit(paddr, BLANK_CTRL_OFS)) prdata[15:0] = blank_q;
      if (hit(paddr, AUX_CTRL_OFS)) prdata[6:0] = {pre_q, sel_q};
      if (hit(paddr, BLANK_TIME_OFS)) prdata[15:0] = time_q;
      if (hit(paddr, STATUS_OFS)) prdata[16:0] = {blank, cnt_q};
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   a_gate_stop: assert property (@(posedge pclk) disable iff (!presetn)
      !gate_q[GATE_EN_BIT] |=> !gating_clk) else $error("gating clock ran while off");
   a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
      (gate_q[14:10] == 5'h00) && (blank_q[9:6] == 4'h0)) else $error("reserved bit set");
   a_duty_write: assert property (@(posedge pclk) disable iff (!presetn)
      wr && hit(paddr, DUTY_OFS) |=> master_duty_value == $past(pwdata[15:0]))
      else $error("duty write lost");
   a_trig_reload: assert property (@(posedge pclk) disable iff (!presetn)
      trig |=> cnt_q == $past(time_q)) else $error("counter not reloaded");
   a_no_trig: assert property (@(posedge pclk) disable iff (!presetn)
      blank_q[15:12] == 4'h0 |-> !trig) else $error("disabled edge triggered");
   a_count_down: assert property (@(posedge pclk) disable iff (!presetn)
      edge_blank && !trig |=> cnt_q == $past(cnt_q) - 16'h0001) else $error("bad count");
   a_fault_mask: assert property (@(posedge pclk) disable iff (!presetn)
      blank && blank_q[FLT_EN_BIT] |=> !fault_out) else $error("fault not blanked");
   a_fault_pass: assert property (@(posedge pclk) disable iff (!presetn)
      !blank_q[FLT_EN_BIT] |=> fault_out == $past(flt)) else $error("fault not passed");
   a_state_high: assert property (@(posedge pclk) disable iff (!presetn)
      blank_q[HH_BIT] && hs && blank_q[CL_EN_BIT] |=> !current_limit_out)
      else $error("limit not blanked");
   a_select_blank: assert property (@(posedge pclk) disable iff (!presetn)
      blank_q[SEL_HI_BIT] && sel_sig |-> blank) else $error("select blank missed");
   c_trigger: cover property (@(posedge pclk) disable iff (!presetn) trig);
   c_count_out: cover property (@(posedge pclk) disable iff (!presetn)
      edge_blank ##1 !edge_blank);
   c_gclk_toggle: cover property (@(posedge pclk) disable iff (!presetn)
      $rose(gating_clk));
endmodule
`default_nettype wire

// ===== verif/power_stage_model.sv
`default_nettype none
// ---------------------------------------------------------------
// Power stage and sensing model
// ---------------------------------------------------------------
module power_stage_model (
   input  wire logic        pclk,
   output logic             high_side_output,
   output logic             low_side_output,
   output logic             fault_in,
   output logic             current_limit_in,
   output logic      [15:0] blank_sources
);
   timeunit 1ns;
   timeprecision 1ps;
   // Quiet stage at power-up, no fault sensed
   initial begin
      high_side_output = 1'b0;
      low_side_output = 1'b0;
      fault_in = 1'b0;
      current_limit_in = 1'b0;
      blank_sources = 16'h0000;
   end
   // Levels change just after an edge, as a real stage is asynchronous anyway
   task automatic drive(input logic h, l, f, c, input logic [15:0] s);
      @(posedge pclk);
      high_side_output <= h;
      low_side_output <= l;
      fault_in <= f;
      current_limit_in <= c;
      blank_sources <= s;
   endtask
endmodule
`default_nettype wire

// ===== verif/pwm_blanking_and_gating_clock_tb.sv
`default_nettype none
module pwm_blanking_and_gating_clock_tb;
   import blank_gate_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, hs, ls, flt, cl;
   logic fault_out, current_limit_out, gating_clk;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] src, duty;
   int          errors, n_compared;
   // ---------------------------------------------------------------
   // Clock, model and design
   // ---------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   power_stage_model pm (.pclk(pclk), .high_side_output(hs), .low_side_output(ls),
      .fault_in(flt), .current_limit_in(cl), .blank_sources(src));
   blank_gate dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .high_side_output(hs), .low_side_output(ls), .blank_sources(src),
      .fault_in(flt), .current_limit_in(cl), .fault_out(fault_out),
      .current_limit_out(current_limit_out), .gating_clk(gating_clk),
      .master_duty_value(duty));
   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic report_and_stop();
      $display("compared %0d, mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: %s got %h want %h", $time, what, seen, exp);
      end
   endtask
   // One APB transfer; read data and error taken at the pready edge only
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      for (i = 0; pready !== 1'b1 && i < 20; i++) @(posedge pclk);
      if (i == 20) begin
         errors++;
         report_and_stop();
      end
      rd = prdata;
      if (pslverr === 1'b1) rd = 32'hEEEEEEEE;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task automatic wait_clk(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_regs();
      apb(0, GATE_CLK_OFS, 0);   check(rd, 32'h0, "gate reset");
      apb(0, DUTY_OFS, 0);       check(rd, 32'h0, "duty reset");
      apb(1, GATE_CLK_OFS, 32'hFFFF_7FFF); apb(0, GATE_CLK_OFS, 0);
      check(rd, 32'h0000_03FF, "gate reserved");
      apb(1, BLANK_CTRL_OFS, 32'hFFFF_FFFF); apb(0, BLANK_CTRL_OFS, 0);
      check(rd, 32'h0000_FC3F, "blank reserved");
      apb(1, DUTY_OFS, 32'h0001_A5C3); apb(0, DUTY_OFS, 0);
      check(rd, 32'h0000_A5C3, "duty read");
      check(duty, 16'hA5C3, "duty port");
      apb(1, 8'h3C, 32'h1234); check(rd, 32'hEEEEEEEE, "unmapped");
      apb(1, BLANK_CTRL_OFS, 0); apb(1, GATE_CLK_OFS, 0);
      $display("registers test done");
   endtask
   // Counts level changes over n edges, starting just after the current edge
   task automatic count_flips(input int n, output int flips);
      logic last;
      #1;
      flips = 0;
      last  = gating_clk;
      repeat (n) begin
         @(posedge pclk);
         #1;
         if (gating_clk !== last) flips++;
         last = gating_clk;
      end
   endtask
   // Divider 1: level flips every 2 clocks, or every 6 with prescale 3
   task automatic t_gate();
      int flips;
      apb(1, AUX_CTRL_OFS, 0); apb(1, GATE_CLK_OFS, 32'h8001); wait_clk(4);
      count_flips(40, flips);
      check(flips, 20, "gate flips");
      apb(1, AUX_CTRL_OFS, 32'h30); wait_clk(8);
      count_flips(48, flips);
      check(flips, 8, "gate prescaled");
      apb(1, GATE_CLK_OFS, 32'h0001); wait_clk(6);
      flips = 0;
      repeat (20) begin
         @(posedge pclk);
         #1;
         if (gating_clk !== 1'b0) flips++;
      end
      check(flips, 0, "gate stopped");
      $display("gating clock test done");
   endtask
   // Level blanking on output states and selected signal, per input enable
   task automatic t_state();
      pm.drive(1, 0, 1, 1, 16'h0); apb(1, BLANK_CTRL_OFS, 32'h0808); wait_clk(5);
      check(fault_out, 0, "fault masked");
      check(current_limit_out, 1, "limit passes");
      pm.drive(0, 0, 1, 1, 16'h0); wait_clk(5);
      check(fault_out, 1, "fault passes");
      apb(1, BLANK_CTRL_OFS, 32'h0401); wait_clk(5);
      check({fault_out, current_limit_out}, 2'b10, "low side low");
      apb(1, AUX_CTRL_OFS, 32'h2); apb(1, BLANK_CTRL_OFS, 32'h0C20);
      pm.drive(0, 1, 1, 1, 16'h0004); wait_clk(5);
      check({fault_out, current_limit_out}, 2'b00, "sel high");
      apb(1, BLANK_CTRL_OFS, 32'h0C10); wait_clk(5);
      check({fault_out, current_limit_out}, 2'b11, "sel low idle");
      apb(1, BLANK_CTRL_OFS, 32'h0C06); wait_clk(5);
      check({fault_out, current_limit_out}, 2'b00, "side states");
      $display("state blanking test done");
   endtask
   // Rising edge armed: blanked from detection through 8 counter clocks
   task automatic t_edge();
      apb(1, BLANK_TIME_OFS, 32'h8); apb(1, BLANK_CTRL_OFS, 32'h8800); wait_clk(5);
      pm.drive(1, 1, 1, 1, 16'h0); wait_clk(6);
      check(fault_out, 0, "edge blanked");
      wait_clk(6);
      check(fault_out, 0, "window last clock");
      wait_clk(1);
      check(fault_out, 1, "window over");
      pm.drive(0, 1, 1, 1, 16'h0); wait_clk(6);
      check(fault_out, 1, "fall ignored");
      apb(1, BLANK_CTRL_OFS, 32'h1800); wait_clk(5);
      pm.drive(0, 0, 1, 1, 16'h0); wait_clk(6);
      check(fault_out, 0, "low fall blanked");
      check(current_limit_out, 1, "limit not blanked");
      $display("edge blanking test done");
   endtask
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      errors = 0; n_compared = 0; presetn = 1'b0;
      psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
      wait_clk(10);
      presetn <= 1'b1;
      t_regs();
      t_gate();
      t_state();
      t_edge();
      report_and_stop();
   end
endmodule
`default_nettype wire
